// ===== core/cgc_pkg.sv
package cgc_pkg;

    // ==================================================================
    // Register map
    localparam logic [3:0]  ADDR_CACHE_CONFIG  = 4'h0;
    localparam logic [3:0]  ADDR_CACHE_TAG_LOW = 4'h4;
    localparam logic [3:0]  ADDR_GEOMETRY      = 4'h8;

    // ==================================================================
    // Config register fields
    localparam int          SIZE_MODE_POS      = 12;
    localparam int          IC_LSB             = 9;
    localparam int          DC_LSB             = 5;
    localparam int          WB_LSB             = 24;
    localparam logic        SIZE_MODE_SMALL    = 1'h1;
    localparam logic [2:0]  IC_CODE_4K         = 3'h2;
    localparam logic [3:0]  DC_CODE_1K         = 4'h0;
    localparam logic [3:0]  WB_PATTERN_RESET   = 4'h0;
    localparam logic [31:0] CFG_FIXED_MASK     = 32'h00001FE0;
    localparam logic [31:0] CFG_RW_MASK        = 32'hFFFFE01F;
    localparam logic [31:0] CFG_RESET          = 32'h00000000;
    localparam logic [31:0] TAG_RESET          = 32'h00000000;

    // ==================================================================
    // Cache capacities in bytes
    localparam int          ICACHE_BYTES       = 4096;
    localparam int          DCACHE_BYTES       = 1024;

    // Writeback transfer patterns
    typedef enum logic [3:0] {
        pattern_word_every_cycle     = 4'h0,
        pattern_word_alternate_cycle = 4'h3
    } cgc_wb_pattern_t;

    // Maintenance address outputs
    typedef struct packed {
        logic [19:0] icache_addr;
        logic [3:0]  dcache_addr;
    } cgc_maint_addr_t;

endpackage : cgc_pkg

// ===== core/cgc_top.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Instruction cache is 4 KB and data cache is 1 KB.
// - Instruction cache maintenance uses tag-low bits 31..12 as address.
// - Data cache maintenance uses tag-low bits 13..10 as address.
// - Config bit 12 reads as 1, small-capacity organisation.
// - Config bits 11..9 read as 010, a 4 KB instruction cache.
// - Config bits 8..5 read as 0000, a 1 KB data cache.
//
// Register map, byte offsets on the register port
//   0x0  cache configuration: writable except the geometry bits 12..5
//   0x4  cache tag low: fully writable, feeds the maintenance addresses
//   0x8  geometry summary: instruction and data capacity in KB, read-only
//   Other offsets read as zero and ignore writes
//
// Timing
//   A write is taken on the strobe edge; outputs change on that same edge.
//   Read data stand only in the cycle after the read strobe, else zero.
//   Back-to-back strobes are fine; the port never stalls the master.
//   A read in the cycle after a write already sees the new value.
//
// Limitations
//   The writeback pattern is not forced; a wrong value is only flagged,
//   so software that misprograms it sees pattern_bad rise, and fall once the field is rewritten to 0.
//   Capacities are parameters, but the size codes stay fixed; changing
//   the parameters alone only alters the geometry summary word.
//   Maintenance addresses follow the tag register and nothing else, so
//   they hold their value between tag writes.
module cgc_top #(
    parameter int ICACHE_BYTES = cgc_pkg::ICACHE_BYTES,
    parameter int DCACHE_BYTES = cgc_pkg::DCACHE_BYTES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // Register port
    input  wire logic [3:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    // Maintenance addressing and pattern
    output cgc_pkg::cgc_maint_addr_t     maint_addr,
    output logic      [3:0]              writeback_pattern_field,
    output logic                         pattern_bad
);

    // ==================================================================
    // Fixed geometry
    function automatic logic [31:0] fixed_fields();
        logic [31:0] v;
        v = 32'h00000000;
        v[cgc_pkg::SIZE_MODE_POS]           = cgc_pkg::SIZE_MODE_SMALL;
        v[cgc_pkg::IC_LSB +: 3]             = cgc_pkg::IC_CODE_4K;
        v[cgc_pkg::DC_LSB +: 4]             = cgc_pkg::DC_CODE_1K;
        return v;
    endfunction : fixed_fields

    // Capacities in KB, readable for software sizing
    localparam logic [15:0] IC_KB = 16'(ICACHE_BYTES / 1024);
    localparam logic [15:0] DC_KB = 16'(DCACHE_BYTES / 1024);

    // ==================================================================
    // Address decode
    // One write hit test shared by both writable registers, so offsets cannot drift apart
    function automatic logic strobe_hit(input logic       strobe,
                                        input logic [3:0] addr,
                                        input logic [3:0] target);
        return strobe && (addr == target);
    endfunction : strobe_hit

    // ==================================================================
    // Registers
    logic [31:0]              cfg_ff;
    logic [31:0]              nxt_cfg;
    logic [31:0]              tag_ff;
    logic [31:0]              nxt_tag;
    logic [31:0]              rdata_ff;
    logic [31:0]              nxt_rdata;
    cgc_pkg::cgc_maint_addr_t maint_ff;
    cgc_pkg::cgc_maint_addr_t nxt_maint;
    logic [3:0]               wbp_ff;
    logic [3:0]               nxt_wbp;
    logic                     bad_ff;
    logic                     nxt_bad;

    // ==================================================================
    // Configuration register
    // Fixed bits are never stored, so a write cannot disturb them
    always_comb begin
        nxt_cfg = cfg_ff;
        if (strobe_hit(reg_wr, reg_addr, cgc_pkg::ADDR_CACHE_CONFIG)) begin
            nxt_cfg = reg_wdata & cgc_pkg::CFG_RW_MASK;
        end
    end

    // Configuration storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff <= cgc_pkg::CFG_RESET;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ==================================================================
    // Tag-low register
    // Whole word is writable; the maintenance addresses are cut from it
    always_comb begin
        nxt_tag = tag_ff;
        if (strobe_hit(reg_wr, reg_addr, cgc_pkg::ADDR_CACHE_TAG_LOW)) begin
            nxt_tag = reg_wdata;
        end
    end

    // Tag storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tag_ff <= cgc_pkg::TAG_RESET;
        end else begin
            tag_ff <= nxt_tag;
        end
    end

    // ==================================================================
    // Maintenance addresses
    // Taken from the next tag value so they land in step with the tag
    always_comb begin
        nxt_maint             = maint_ff;
        nxt_maint.icache_addr = nxt_tag[31:12];
        nxt_maint.dcache_addr = nxt_tag[13:10];
    end

    // Maintenance address storage, so the outputs come from flip-flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            maint_ff <= '0;
        end else begin
            maint_ff <= nxt_maint;
        end
    end

    // ==================================================================
    // Writeback pattern and misuse flag
    // Flags a pattern other than word-every-cycle; hardware still obeys
    always_comb begin
        nxt_wbp = nxt_cfg[cgc_pkg::WB_LSB +: 4];
        nxt_bad = nxt_wbp != 4'(cgc_pkg::pattern_word_every_cycle);
    end

    // Pattern storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wbp_ff <= cgc_pkg::WB_PATTERN_RESET;
            bad_ff <= 1'b0;
        end else begin
            wbp_ff <= nxt_wbp;
            bad_ff <= nxt_bad;
        end
    end

    // ==================================================================
    // Read data
    // Zero outside the answer cycle, so a stale word is never mistaken
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                cgc_pkg::ADDR_CACHE_CONFIG: begin
                    nxt_rdata = cfg_ff | fixed_fields();
                end
                cgc_pkg::ADDR_CACHE_TAG_LOW: begin
                    nxt_rdata = tag_ff;
                end
                cgc_pkg::ADDR_GEOMETRY: begin
                    nxt_rdata = {IC_KB, DC_KB};
                end
                default: begin
                    nxt_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // Read data storage; the answer stands for exactly one cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==================================================================
    // Outputs, straight from the flip-flops

    assign reg_rdata               = rdata_ff;
    assign maint_addr              = maint_ff;
    assign writeback_pattern_field = wbp_ff;
    assign pattern_bad             = bad_ff;

endmodule : cgc_top
`default_nettype wire

// ===== test/cgc_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Geometry and tag address checks
module cgc_properties (
    // Watched ports
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire cgc_pkg::cgc_maint_addr_t maint_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Strobes; read data land one cycle later
    wire logic cr = reg_rd && reg_addr == 4'h0;
    wire logic tw = reg_wr && reg_addr == 4'h4;
    chk_mode_bit: assert property (cr |=> reg_rdata[12]) else $error("mode bit");
    chk_ic_code: assert property (cr |=> reg_rdata[11:9] == 3'h2) else $error("ic code");
    chk_dc_code: assert property (cr |=> reg_rdata[8:5] == 4'h0) else $error("dc code");
    chk_fixed_bits: assert property (reg_wr && reg_addr == 4'h0 ##1 cr |=>
        reg_rdata[12:5] == 8'hA0) else $error("fixed bits");
    chk_ic_addr: assert property (tw |=> maint_addr.icache_addr == $past(reg_wdata[31:12]))
        else $error("ic addr");
    chk_dc_addr: assert property (tw |=> maint_addr.dcache_addr == $past(reg_wdata[13:10]))
        else $error("dc addr");
    chk_geo_sizes: assert property (reg_rd && reg_addr == 4'h8 |=> reg_rdata == 32'h00040001)
        else $error("sizes");
    cover property (cr);
    cover property (tw);
    cover property (reg_rd && reg_addr == 4'h8);
endmodule : cgc_properties
bind cgc_top cgc_properties u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .maint_addr(maint_addr));
`default_nettype wire

// ===== test/test_cache_geometry_config.sv
`timescale 1ns/1ns
`default_nettype none
module test_cache_geometry_config;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, bad;
    logic [3:0] reg_addr = 4'h0, wbp;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    cgc_pkg::cgc_maint_addr_t maint_addr;
    int err_total = 0, compares = 0, cyc = 0;
    always #20 clk = ~clk;
    cgc_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .maint_addr(maint_addr),
        .writeback_pattern_field(wbp), .pattern_bad(bad));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One strobe; returns inside the cycle where read data stand
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
        reg_rd <= 0;
        #1;
    endtask : acc
    task automatic finish_test;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // Hang guard, far above the few dozen cycles used
    always @(posedge clk) if (++cyc > 500) begin
        err_total++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 0;
        acc(0, 4'h0, 0); chk(reg_rdata, 32'h00001400);
        acc(1, 4'h0, 32'hFFFFFFFF);
        acc(0, 4'h0, 0); chk(reg_rdata, 32'hFFFFF41F);
        chk({bad, wbp}, 5'h1F);
        acc(1, 4'h0, 0);
        acc(0, 4'h0, 0); chk(reg_rdata[11:5], 7'h20);
        chk(reg_rdata[8:5], 4'h0);
        chk({bad, wbp}, 5'h00);
        acc(1, 4'h4, 32'hA5A52C00); chk(maint_addr, 24'hA5A52B);
        acc(1, 4'h4, 32'h00000400); chk(maint_addr, 24'h000001);
        acc(1, 4'h8, 32'hFFFFFFFF);
        acc(0, 4'h8, 0); chk(reg_rdata, 32'h00040001);
        @(posedge clk); #1; chk(reg_rdata, 32'h0);
        acc(0, 4'hC, 0); chk(reg_rdata, 32'h0);
        finish_test();
    end
endmodule : test_cache_geometry_config
`default_nettype wire
